// ===== shared/idac_pkg.sv
`default_nettype none
package idac_pkg;
  // ------------------------------------------------------------
  // Register map (special-function-register addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'hB9;
  // Data byte addresses are not printed; chosen locally
  localparam logic [7:0] DATA_H_ADDR = 8'hBA;
  localparam logic [7:0] DATA_L_ADDR = 8'hBB;
  localparam logic [7:0] CTRL_RESET  = 8'h73;
  localparam logic [7:0] CTRL_WMASK  = 8'hF7;
  localparam logic [7:0] DATA_RESET  = 8'h00;

  // ------------------------------------------------------------
  // Control field positions
  // ------------------------------------------------------------
  localparam int EN_BIT   = 7;
  localparam int SRC_HI   = 6;
  localparam int SRC_LO   = 4;
  localparam int RJST_BIT = 2;
  localparam int OMD_HI   = 1;
  localparam int OMD_LO   = 0;
  localparam int WORD_W   = 12;

  // ------------------------------------------------------------
  // Update source codes
  // ------------------------------------------------------------
  localparam logic [2:0] SRC_T0    = 3'h0;
  localparam logic [2:0] SRC_T1    = 3'h1;
  localparam logic [2:0] SRC_T2    = 3'h2;
  localparam logic [2:0] SRC_T3    = 3'h3;
  localparam logic [2:0] SRC_RISE  = 3'h4;
  localparam logic [2:0] SRC_FALL  = 3'h5;
  localparam logic [2:0] SRC_ANY   = 3'h6;
  localparam logic [2:0] SRC_WRITE = 3'h7;

  // Timer overflow inputs, one group per timer
  typedef struct packed {
    logic       t3_split8;
    logic       t3_ovf_lo;
    logic       t3_ovf_hi;
    logic       t2_split8;
    logic       t2_ovf_lo;
    logic       t2_ovf_hi;
    logic       t1_ovf;
    logic       t0_ovf;
  } timer_ovf_s;

  // Register bus write/read request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;
endpackage
`default_nettype wire

// ===== rtl/current_dac_update_control.sv
// Functional notes
// - In a pin-edge mode both data bytes are only staged and the latch holds until the chosen pin edge.
// - On a qualifying event the staged high:low word is copied into the converter input latch.
// - Code 100 fires on a rising pin edge, 101 on a falling edge and 110 on either edge.
// - Left-justified: word 11..4 from high byte 7..0 and word 3..0 from low byte 7..4.
// - Right-justified: word 11..8 from high byte 3..0 and word 7..0 from low byte 7..0.
// - Control bit 2 clear selects left and set selects right justification.
// - Control bits 1..0 select full scale, 11 is 2 mA and the reset value, 10/01/00 are 1/0.5/0.25 mA.
// - Control bit 7 enables the channel when set.
// - Codes 000 to 011 update on an overflow of timer 0 to 3.
// - In code 111 a low-byte write is staged and a high-byte write latches both bytes at once.
// - In timer modes both bytes are held until the timer overflows, then copied.
// - Timers 2 and 3 use the low-byte overflow in 8-bit mode and high-byte overflow in 16-bit mode.
`timescale 1ns/10ps
`default_nettype none
module current_dac_update_control
  import idac_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  // Register bus
  input  wire idac_pkg::sfr_req_s    sfr_req,
  output logic [7:0]                 sfr_rdata,
  // Update events
  input  wire idac_pkg::timer_ovf_s  timer_ovf,
  input  wire logic                  conv_start_pin,
  // Converter side
  output logic [11:0]                dac_code,
  output logic                       channel_enable,
  output logic [1:0]                 full_scale_sel,
  output logic                       update_strobe
);
  import idac_pkg::*;

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  data_h_q, data_h_d;
  logic [7:0]  data_l_q, data_l_d;
  logic [11:0] latch_q, latch_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        sync1_q, sync1_d;
  logic        sync2_q, sync2_d;
  logic        prev_q, prev_d;
  logic        init_q, init_d;

  logic [2:0]  update_source_sel;
  logic        right_justify_sel;
  logic        rise, fall, t2_evt, t3_evt, fire, wr_h, wr_l, wr_c;
  logic [7:0]  stage_h, stage_l;
  logic [11:0] word;

  assign update_source_sel = ctrl_q[SRC_HI:SRC_LO];
  assign right_justify_sel = ctrl_q[RJST_BIT];

  // ------------------------------------------------------------
  // Event detection
  // ------------------------------------------------------------
  // The first edge sample after reset is suppressed: prev then holds its reset zero, not a pin sample
  assign rise   = init_q & sync2_q & ~prev_q;
  assign fall   = init_q & ~sync2_q & prev_q;
  assign t2_evt = timer_ovf.t2_split8 ? timer_ovf.t2_ovf_lo : timer_ovf.t2_ovf_hi;
  assign t3_evt = timer_ovf.t3_split8 ? timer_ovf.t3_ovf_lo : timer_ovf.t3_ovf_hi;
  assign wr_h   = sfr_req.wr & (sfr_req.addr == DATA_H_ADDR);
  assign wr_l   = sfr_req.wr & (sfr_req.addr == DATA_L_ADDR);
  assign wr_c   = sfr_req.wr & (sfr_req.addr == CTRL_ADDR);

  always_comb
  begin
    case (update_source_sel)
      SRC_T0:    fire = timer_ovf.t0_ovf;
      SRC_T1:    fire = timer_ovf.t1_ovf;
      SRC_T2:    fire = t2_evt;
      SRC_T3:    fire = t3_evt;
      SRC_RISE:  fire = rise;
      SRC_FALL:  fire = fall;
      SRC_ANY:   fire = rise | fall;
      SRC_WRITE: fire = wr_h;
      default:   fire = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Data mapping
  // ------------------------------------------------------------
  // A write landing with the event is included, so a high-byte write in
  // on-demand mode latches the freshly written byte
  // Built from the bus directly, not from the register next values, so the
  // latch path has no loop back through the register file logic
  always_comb
  begin
    stage_h = data_h_q;
    stage_l = data_l_q;
    if (wr_h)
      stage_h = sfr_req.wdata;
    if (wr_l)
      stage_l = sfr_req.wdata;
  end

  always_comb
  begin
    if (right_justify_sel)
      word = {stage_h[3:0], stage_l};
    else
      word = {stage_h, stage_l[7:4]};
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  // Reserved bit 3 is masked on write so it always reads back as zero
  always_comb
  begin
    ctrl_d   = ctrl_q;
    data_h_d = data_h_q;
    data_l_d = data_l_q;
    if (wr_c)
      ctrl_d = sfr_req.wdata & CTRL_WMASK;
    if (wr_h)
      data_h_d = sfr_req.wdata;
    if (wr_l)
      data_l_d = sfr_req.wdata;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q   <= CTRL_RESET;
      data_h_q <= DATA_RESET;
      data_l_q <= DATA_RESET;
    end
    else if (clk_en)
    begin
      ctrl_q   <= ctrl_d;
      data_h_q <= data_h_d;
      data_l_q <= data_l_d;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Registered for timing; the bus sees it one cycle after the strobe and
  // unmapped addresses read as zero
  always_comb
  begin
    rdata_d = rdata_q;
    if (sfr_req.rd)
    begin
      case (sfr_req.addr)
        CTRL_ADDR:   rdata_d = ctrl_q;
        DATA_H_ADDR: rdata_d = data_h_q;
        DATA_L_ADDR: rdata_d = data_l_q;
        default:     rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata_q <= 8'h00;
    else if (clk_en)
      rdata_q <= rdata_d;
  end

  // ------------------------------------------------------------
  // Converter input latch
  // ------------------------------------------------------------
  always_comb
  begin
    latch_d = latch_q;
    if (fire)
      latch_d = word;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      latch_q <= 12'h000;
    else if (clk_en)
      latch_q <= latch_d;
  end

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  // Only the second stage and its delayed copy prev feed the edge logic; the first may be metastable
  always_comb
  begin
    sync1_d = conv_start_pin;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
    init_d  = 1'b1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
      init_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
      init_q  <= init_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign sfr_rdata      = rdata_q;
  assign dac_code       = latch_q;
  assign channel_enable = ctrl_q[EN_BIT];
  assign full_scale_sel = ctrl_q[OMD_HI:OMD_LO];
  assign update_strobe  = fire & clk_en;
endmodule
`default_nettype wire

// ===== dv/current_dac_update_control_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module current_dac_update_control_monitor
  import idac_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  // Requests and events
  input  wire idac_pkg::sfr_req_s    sfr_req,
  input  wire idac_pkg::timer_ovf_s  timer_ovf,
  input  wire logic                  conv_start_pin,
  // Converter side
  input  wire logic [11:0]           dac_code,
  input  wire logic                  channel_enable,
  input  wire logic [1:0]            full_scale_sel,
  input  wire logic                  update_strobe
);
  logic [7:0]  ctrl_q;
  logic [7:0]  hi_q;
  logic [7:0]  lo_q;
  wire  logic        wr   = clk_en && sfr_req.wr;
  wire  logic [2:0]  src  = ctrl_q[6:4];
  wire  logic [11:0] word = ctrl_q[2] ? {hi_q[3:0], lo_q} : {hi_q, lo_q[7:4]};

  // Shadow copy of the registers, so events can be judged against the staged bytes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      {ctrl_q, hi_q, lo_q} <= {CTRL_RESET, DATA_RESET, DATA_RESET};
    else if (wr && sfr_req.addr == CTRL_ADDR)
      ctrl_q <= sfr_req.wdata & CTRL_WMASK;
    else if (wr && sfr_req.addr == DATA_H_ADDR)
      hi_q <= sfr_req.wdata;
    else if (wr && sfr_req.addr == DATA_L_ADDR)
      lo_q <= sfr_req.wdata;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_en; channel_enable == ctrl_q[7]; endproperty
  a_en: assert property (p_en) else $error("enable differs");
  property p_fs; full_scale_sel == ctrl_q[1:0]; endproperty
  a_fs: assert property (p_fs) else $error("range differs");
  property p_dem; wr && sfr_req.addr == DATA_H_ADDR && src == SRC_WRITE |-> update_strobe; endproperty
  a_dem: assert property (p_dem) else $error("no update on write");
  property p_t0; clk_en && src == SRC_T0 && timer_ovf.t0_ovf |-> update_strobe; endproperty
  a_t0: assert property (p_t0) else $error("no update on timer");
  property p_t2; clk_en && src == SRC_T2 &&
    (timer_ovf.t2_split8 ? timer_ovf.t2_ovf_lo : timer_ovf.t2_ovf_hi) |-> update_strobe; endproperty
  a_t2: assert property (p_t2) else $error("no update on byte overflow");
  property p_hold; !update_strobe |=> $stable(dac_code); endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_rise; clk_en && src == SRC_RISE && $rose(conv_start_pin) ##1
    (clk_en && src == SRC_RISE) [*2] |-> update_strobe; endproperty
  a_rise: assert property (p_rise) else $error("no update on pin");
  property p_word; update_strobe |=> dac_code == word; endproperty
  a_word: assert property (p_word) else $error("latched word wrong");
endmodule
bind current_dac_update_control current_dac_update_control_monitor mon (.clk(clk),
  .reset(reset), .clk_en(clk_en), .sfr_req(sfr_req), .timer_ovf(timer_ovf),
  .conv_start_pin(conv_start_pin), .dac_code(dac_code), .channel_enable(channel_enable),
  .full_scale_sel(full_scale_sel), .update_strobe(update_strobe));
`default_nettype wire

// ===== dv/timer_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module timer_pin_model
  import idac_pkg::*;
(
  // Clock
  input  wire logic                clk,
  // Events towards the block
  output var idac_pkg::timer_ovf_s timer_ovf,
  output var logic                 conv_start_pin
);
  initial timer_ovf = '0;
  initial conv_start_pin = 1'b0;
  // Split-mode bits are levels and survive; overflow bits last one cycle
  task automatic pulse(input logic [7:0] m);
    @(posedge clk) timer_ovf <= m;
    @(posedge clk) timer_ovf <= m & 8'h90;
  endtask
  // Pin is held well past synchroniser latency before the caller moves on
  task automatic set_pin(input logic v);
    @(posedge clk) conv_start_pin <= v;
    repeat (6) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== dv/current_dac_update_control_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module current_dac_update_control_test;
  import idac_pkg::*;
  logic clk = 1'b0, reset = 1'b1, clk_en = 1'b1, conv_start_pin, channel_enable, update_strobe;
  sfr_req_s    sfr_req = '0;
  timer_ovf_s  timer_ovf;
  logic [7:0]  sfr_rdata;
  logic [11:0] dac_code, cur;
  logic [1:0]  full_scale_sel;
  int          mismatches = 0, total_checks = 0, cycles = 0;
  always #2.5 clk = ~clk;
  current_dac_update_control dut (.clk(clk), .reset(reset), .clk_en(clk_en), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .timer_ovf(timer_ovf), .conv_start_pin(conv_start_pin),
    .dac_code(dac_code), .channel_enable(channel_enable), .full_scale_sel(full_scale_sel),
    .update_strobe(update_strobe));
  timer_pin_model ev (.clk(clk), .timer_ovf(timer_ovf), .conv_start_pin(conv_start_pin));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) sfr_req <= {1'b1, 1'b0, a, d};
    @(posedge clk) sfr_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) sfr_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk) sfr_req <= '0;
    #1 `CHK("sfr_rdata", exp, sfr_rdata)
  endtask
  task automatic dac(input logic [11:0] exp);
    #1 `CHK("dac_code", exp, dac_code)
  endtask
  task automatic load(input logic [7:0] h, input logic [7:0] l);
    wr(DATA_L_ADDR, l);
    wr(DATA_H_ADDR, h);
  endtask
  task automatic t_regs;
    rd(CTRL_ADDR, 8'h73);
    `CHK("full_scale_sel", 2'h3, full_scale_sel)
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      wr(CTRL_ADDR, 8'hF8 | 8'(k));
      rd(CTRL_ADDR, 8'hF0 | 8'(k));
      `CHK("full_scale_sel", 2'(k), full_scale_sel)
      `CHK("channel_enable", 1'b1, channel_enable)
    end
    $display("t_regs done");
  endtask
  task automatic t_demand;
    wr(CTRL_ADDR, 8'h70);
    wr(DATA_L_ADDR, 8'hAB);
    dac(12'h000);
    `CHK("channel_enable", 1'b0, channel_enable)
    wr(DATA_H_ADDR, 8'h12);
    dac(12'h12A);
    wr(CTRL_ADDR, 8'hF4);
    wr(DATA_H_ADDR, 8'hC5);
    dac(12'h5AB);
    @(posedge clk) clk_en <= 1'b0;
    wr(DATA_H_ADDR, 8'h07);
    @(posedge clk) clk_en <= 1'b1;
    dac(12'h5AB);
    cur = 12'h5AB;
    $display("t_demand done");
  endtask
  task automatic t_timer;
    logic [7:0] hit [4] = '{8'h01, 8'h02, 8'h18, 8'h20};
    logic [7:0] miss [4] = '{8'h02, 8'h01, 8'h14, 8'h40};
    for (int s = 0; s < 4; s++)
    begin
      wr(CTRL_ADDR, 8'h84 | 8'(s << 4));
      load(8'(s), 8'h5A);
      dac(cur);
      ev.pulse(miss[s]);
      dac(cur);
      ev.pulse(hit[s]);
      cur = {4'(s), 8'h5A};
      dac(cur);
    end
    $display("t_timer done");
  endtask
  task automatic t_pin;
    for (int s = 4; s < 7; s++)
    begin
      wr(CTRL_ADDR, 8'h84 | 8'(s << 4));
      load(8'(s), 8'hC3);
      ev.set_pin(1'b1);
      if (s != 5) cur = {4'(s), 8'hC3};
      dac(cur);
      load(8'(s + 8), 8'h3C);
      ev.set_pin(1'b0);
      if (s != 4) cur = {4'(s + 8), 8'h3C};
      dac(cur);
    end
    $display("t_pin done");
  endtask
  task automatic t_reset;
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    dac(12'h000);
    `CHK("full_scale_sel", 2'h3, full_scale_sel)
    `CHK("channel_enable", 1'b0, channel_enable)
    rd(CTRL_ADDR, 8'h73);
    $display("t_reset done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_demand();
    t_timer();
    t_pin();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
